// >>> design/prx_meas_config.sv
/*
  Configuration registers and measurement sequencer of the proximity
  engine: timing, thresholds, persistence filter, LED pulsing and the
  analog settings. Assumes the serial bus front end presents a simple
  register port and that the enable bits come from the enable register.
*/
`default_nettype none

module prx_meas_config #(
  parameter int STEP_CYCLES = prx_pkg::STEP_CYCLES,
  parameter int LED_HALF_CYCLES = prx_pkg::LED_HALF_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Enable bits.
  input wire logic power_on,
  input wire logic proximity_enable_bit,
  input wire logic wait_enable,
  // Converter result.
  input wire logic [15:0] prox_count,
  // Analog and LED controls.
  output logic led_driver_output,
  output logic [1:0] led_drive_strength,
  output logic reduced_drive_level_bit,
  output logic [1:0] diode_select,
  output logic [1:0] analog_gain,
  output logic integrating,
  // Events.
  output logic cycle_done,
  output logic prox_interrupt,
  output logic out_of_range
);
  import prx_pkg::*;

  // Integration and wait steps from a two's complement register value.
  function automatic logic [8:0] steps_of(input logic [7:0] v);
    steps_of = 9'h100 - {1'b0, v};
  endfunction : steps_of

  logic [7:0] integration_time_q;
  logic [7:0] wait_time_q;
  logic [15:0] low_thr_q;
  logic [15:0] high_thr_q;
  logic [3:0] persist_q;
  logic [1:0] config_q;
  logic [7:0] led_pulse_count_q;
  logic [5:0] control_q;
  prx_state_e state_q;
  logic [11:0] step_cnt_q;
  logic [11:0] step_target_q;
  logic [7:0] pulses_left_q;
  logic [7:0] pulse_latch_q;
  logic [15:0] half_cnt_q;
  logic [3:0] oor_cnt_q;
  logic long_wait_q;
  logic step;
  logic cycle_end;
  logic oor_now;
  logic start;

  assign start = (state_q == PRX_IDLE) && power_on && proximity_enable_bit;
  assign cycle_end = (state_q == PRX_INTEG) && step && (step_cnt_q + 12'h001 >= step_target_q);
  assign oor_now = (prox_count < low_thr_q) || (prox_count > high_thr_q);

  // Register writes; reserved bits are not stored.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      integration_time_q <= RST_INTEG_TIME;
      wait_time_q <= RST_WAIT_TIME;
      low_thr_q <= {RST_THRESHOLD, RST_THRESHOLD};
      high_thr_q <= {RST_THRESHOLD, RST_THRESHOLD};
      persist_q <= RST_PERSIST;
      config_q <= RST_CONFIG;
      led_pulse_count_q <= RST_PULSE_CNT;
      control_q <= RST_CONTROL;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        OFS_INTEG_TIME: integration_time_q <= reg_wdata;
        OFS_WAIT_TIME: wait_time_q <= reg_wdata;
        OFS_LOW_THR_LO: low_thr_q[7:0] <= reg_wdata;
        OFS_LOW_THR_HI: low_thr_q[15:8] <= reg_wdata;
        OFS_HIGH_THR_LO: high_thr_q[7:0] <= reg_wdata;
        OFS_HIGH_THR_HI: high_thr_q[15:8] <= reg_wdata;
        OFS_PERSIST: persist_q <= reg_wdata[PERSIST_LSB +: 4];
        OFS_CONFIG: config_q <= reg_wdata[1:0];
        OFS_PULSE_CNT: led_pulse_count_q <= reg_wdata;
        OFS_CONTROL: control_q <= reg_wdata[7:2];
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped offsets and reserved bits read zero.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      unique case (reg_addr)
        OFS_INTEG_TIME: reg_rdata <= integration_time_q;
        OFS_WAIT_TIME: reg_rdata <= wait_time_q;
        OFS_LOW_THR_LO: reg_rdata <= low_thr_q[7:0];
        OFS_LOW_THR_HI: reg_rdata <= low_thr_q[15:8];
        OFS_HIGH_THR_LO: reg_rdata <= high_thr_q[7:0];
        OFS_HIGH_THR_HI: reg_rdata <= high_thr_q[15:8];
        OFS_PERSIST: reg_rdata <= {persist_q, 4'h0};
        OFS_CONFIG: reg_rdata <= {6'h00, config_q};
        OFS_PULSE_CNT: reg_rdata <= led_pulse_count_q;
        OFS_CONTROL: reg_rdata <= {control_q, 2'h0};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Step pulses of 2.73 ms pace integration and wait.
  prx_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step (
    .ref_clk(ref_clk),
    .reset(reset),
    .run((state_q == PRX_INTEG) || (state_q == PRX_WAIT)),
    .restart(cycle_end),
    .step(step)
  );

  // Sequencer: accumulate pulses, integrate, then optionally wait.
  always_ff @(posedge ref_clk)
  begin
    if (reset || !power_on || !proximity_enable_bit)
    begin
      state_q <= PRX_IDLE;
      step_cnt_q <= 12'h000;
      step_target_q <= 12'h000;
    end
    else
    begin
      unique case (state_q)
        PRX_IDLE:
        begin
          state_q <= PRX_ACCUM;
          step_cnt_q <= 12'h000;
          step_target_q <= {3'h0, steps_of(integration_time_q)};
        end
        PRX_ACCUM:
        begin
          if (pulses_left_q == 8'h00 && !led_driver_output)
          begin
            state_q <= PRX_INTEG;
          end
        end
        PRX_INTEG:
        begin
          if (cycle_end)
          begin
            step_cnt_q <= 12'h000;
            if (wait_enable)
            begin
              state_q <= PRX_WAIT;
              step_target_q <= long_wait_q ?
                12'(steps_of(wait_time_q) * LONG_WAIT_FACTOR) :
                {3'h0, steps_of(wait_time_q)};
            end
            else
            begin
              state_q <= PRX_IDLE;
            end
          end
          else if (step)
          begin
            step_cnt_q <= step_cnt_q + 12'h001;
          end
        end
        PRX_WAIT:
        begin
          if (!wait_enable || (step && step_cnt_q + 12'h001 >= step_target_q))
          begin
            state_q <= PRX_IDLE;
          end
          else if (step)
          begin
            step_cnt_q <= step_cnt_q + 12'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      led_drive_strength <= 2'h0;
      reduced_drive_level_bit <= 1'b0;
      diode_select <= 2'h0;
      analog_gain <= 2'h0;
      pulse_latch_q <= 8'h00;
      long_wait_q <= 1'b0;
    end
    else if (start)
    begin
      led_drive_strength <= control_q[CTRL_DRIVE_LSB - 2 +: 2];
      reduced_drive_level_bit <= config_q[CFG_DRIVE_LEVEL_BIT];
      diode_select <= control_q[CTRL_DIODE_LSB - 2 +: 2];
      analog_gain <= control_q[CTRL_GAIN_LSB - 2 +: 2];
      pulse_latch_q <= led_pulse_count_q;
      long_wait_q <= config_q[CFG_LONG_WAIT_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || state_q != PRX_ACCUM)
    begin
      led_driver_output <= 1'b0;
      half_cnt_q <= 16'h0000;
      pulses_left_q <= start ? led_pulse_count_q : 8'h00;
    end
    else if (half_cnt_q == 16'(LED_HALF_CYCLES - 1))
    begin
      half_cnt_q <= 16'h0000;
      if (led_driver_output)
      begin
        led_driver_output <= 1'b0;
      end
      else if (pulses_left_q != 8'h00)
      begin
        led_driver_output <= 1'b1;
        pulses_left_q <= pulses_left_q - 8'h01;
      end
    end
    else
    begin
      half_cnt_q <= half_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || !proximity_enable_bit)
    begin
      oor_cnt_q <= 4'h0;
      prox_interrupt <= 1'b0;
      cycle_done <= 1'b0;
      out_of_range <= 1'b0;
      integrating <= 1'b0;
    end
    else
    begin
      integrating <= (state_q == PRX_ACCUM) || (state_q == PRX_INTEG);
      cycle_done <= cycle_end;
      prox_interrupt <= 1'b0;
      if (cycle_end)
      begin
        out_of_range <= oor_now;
        if (!oor_now)
        begin
          oor_cnt_q <= 4'h0;
        end
        else if (oor_cnt_q != 4'hF)
        begin
          oor_cnt_q <= oor_cnt_q + 4'h1;
        end
        if (persist_q == 4'h0)
        begin
          prox_interrupt <= 1'b1;
        end
        else if (oor_now && (oor_cnt_q + 4'h1 >= persist_q || oor_cnt_q == 4'hF))
        begin
          prox_interrupt <= 1'b1;
        end
      end
    end
  end

  // Helper: LED rising edges counted through one accumulation phase.
  logic [8:0] edge_cnt_q;
  logic led_prev_q;
  always_ff @(posedge ref_clk)
  begin
    if (reset || state_q == PRX_IDLE)
    begin
      edge_cnt_q <= 9'h000;
      led_prev_q <= 1'b0;
    end
    else
    begin
      led_prev_q <= led_driver_output;
      if (led_driver_output && !led_prev_q)
      begin
        edge_cnt_q <= edge_cnt_q + 9'h001;
      end
    end
  end

  integ_reset_a: assert property (@(posedge ref_clk)
    $past(reset) |-> integration_time_q == 8'hFF)
    else $error("integration time not 0xFF after reset");
  wait_reset_a: assert property (@(posedge ref_clk)
    $past(reset) |-> wait_time_q == 8'hFF)
    else $error("wait time not 0xFF after reset");
  thresh_reset_a: assert property (@(posedge ref_clk)
    $past(reset) |-> low_thr_q == 16'h0000 && high_thr_q == 16'h0000)
    else $error("thresholds not zero after reset");
  persist_reset_a: assert property (@(posedge ref_clk)
    $past(reset) |-> persist_q == 4'h0)
    else $error("persistence not zero after reset");
  every_cycle_irq_a: assert property (@(posedge ref_clk) disable iff (reset)
    cycle_end && persist_q == 4'h0 && proximity_enable_bit |=> prox_interrupt)
    else $error("no interrupt with persistence zero");
  in_range_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    cycle_end && !oor_now && proximity_enable_bit |=> oor_cnt_q == 4'h0)
    else $error("in-range cycle did not clear counter");
  wait_length_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == PRX_WAIT && $past(state_q) == PRX_INTEG |->
    step_target_q == (long_wait_q ?
    12'(steps_of($past(wait_time_q)) * LONG_WAIT_FACTOR) :
    {3'h0, steps_of($past(wait_time_q))}))
    else $error("wait step target wrong");
  no_wait_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    cycle_end && !wait_enable |=> state_q != PRX_WAIT)
    else $error("waited with wait disabled");
  pulse_total_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == PRX_INTEG && $past(state_q) == PRX_ACCUM |-> edge_cnt_q == {1'b0, pulse_latch_q})
    else $error("LED pulse count mismatch");
  gain_stable_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == PRX_INTEG |-> $stable(analog_gain) && $stable(led_drive_strength))
    else $error("analog setting changed mid-cycle");
  integ_length_a: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == PRX_ACCUM && $past(state_q) == PRX_IDLE |->
    step_target_q == {3'h0, steps_of($past(integration_time_q))})
    else $error("integration step target wrong");

endmodule : prx_meas_config

`default_nettype wire

// >>> design/prx_step_timer.sv
/*
  Step timer: produces a one-cycle enable pulse every STEP_CYCLES
  clocks while run is high. Assumes one clock and a synchronous reset.
*/
`default_nettype none

module prx_step_timer #(
  parameter int STEP_CYCLES = 273000
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Control.
  input wire logic run,
  input wire logic restart,
  // Step pulse.
  output logic step
);
  import prx_pkg::*;

  logic [19:0] div_q;

  // Divider restarts at every phase so the first step is a full one.
  always_ff @(posedge ref_clk)
  begin
    if (reset || restart || !run)
    begin
      div_q <= 20'h00000;
      step <= 1'b0;
    end
    else if (div_q == 20'(STEP_CYCLES - 1))
    begin
      div_q <= 20'h00000;
      step <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 20'h00001;
      step <= 1'b0;
    end
  end

endmodule : prx_step_timer

`default_nettype wire

// >>> pkg/prx_pkg.sv
/*
  Shared constants of the proximity measurement configuration block:
  register offsets, reset values, field positions and timing counts.
  Assumes a 100 MHz reference clock and a register port fed by the
  serial bus front end outside this block.
*/
// Notes on behaviour
// - Integration lasts 256 minus integration_time steps of 2.73 ms each.
// - integration_time resets to 0xFF.
// - Wait steps equal 256 minus wait_time, each 2.73 ms.
// - Long-wait bit stretches every wait by twelve.
// - wait_time resets to 0xFF.
// - Four bytes form low and high 16-bit thresholds, reset to zero.
// - Persistence 0 interrupts every cycle; N needs N consecutive out-of-range cycles.
// - Persistence resets to 0x00, so every cycle interrupts.
// - Reduced drive level bit selects the lower LED current range.
// - LED output emits exactly led_pulse_count pulses while accumulating.
// - Drive strength field selects LED current.
// - Gain field sets analog gain 1x, 2x, 4x or 8x.
// - Wait timer runs between cycles only while wait enable is set.
`default_nettype none

package prx_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_INTEG_TIME = 8'h02;
  localparam logic [7:0] OFS_WAIT_TIME = 8'h03;
  localparam logic [7:0] OFS_LOW_THR_LO = 8'h08;
  localparam logic [7:0] OFS_LOW_THR_HI = 8'h09;
  localparam logic [7:0] OFS_HIGH_THR_LO = 8'h0A;
  localparam logic [7:0] OFS_HIGH_THR_HI = 8'h0B;
  localparam logic [7:0] OFS_PERSIST = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h0D;
  localparam logic [7:0] OFS_PULSE_CNT = 8'h0E;
  localparam logic [7:0] OFS_CONTROL = 8'h0F;

  // Reset values.
  localparam logic [7:0] RST_INTEG_TIME = 8'hFF;
  localparam logic [7:0] RST_WAIT_TIME = 8'hFF;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [3:0] RST_PERSIST = 4'h0;
  localparam logic [1:0] RST_CONFIG = 2'h0;
  localparam logic [7:0] RST_PULSE_CNT = 8'h00;
  localparam logic [5:0] RST_CONTROL = 6'h00;

  // Field positions.
  localparam int PERSIST_LSB = 4;
  localparam int CFG_DRIVE_LEVEL_BIT = 0;
  localparam int CFG_LONG_WAIT_BIT = 1;
  localparam int CTRL_GAIN_LSB = 2;
  localparam int CTRL_DIODE_LSB = 4;
  localparam int CTRL_DRIVE_LSB = 6;

  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_US = 2730;
  localparam int STEP_CYCLES = STEP_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam logic [3:0] LONG_WAIT_FACTOR = 4'hC;
  localparam int LED_HALF_NS = 160;
  localparam int LED_HALF_CYCLES = LED_HALF_NS / CLK_PERIOD_NS;

  // Measurement sequencer states.
  typedef enum logic [1:0] {PRX_IDLE, PRX_ACCUM, PRX_INTEG, PRX_WAIT} prx_state_e;

endpackage : prx_pkg

`default_nettype wire

// >>> sim/prx_host_model.sv
/*
  Host model: drives the register port the way the serial front end does.
  Assumes the bench calls its tasks and owns the clock.
*/
`default_nettype none

module prx_host_model (
  // Clock.
  input wire logic ref_clk,
  // Register port.
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  // Read result strobe for the bench.
  output logic rd_vld
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels from time zero.
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    rd_vld = 1'b0;
  end

  // One write strobe; data is scrambled once the strobe has been taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // Read data is registered, so it is valid one cycle after the address.
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    rd_vld = 1'b1;
    @(posedge ref_clk);
    #1;
    rd_vld = 1'b0;
  endtask : rd
endmodule : prx_host_model

`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench of the measurement configuration block.
  Assumes the block's package is compiled first; short step counts.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import prx_pkg::*;
  localparam int SC = 20;
  logic ref_clk, reset, reg_wr, power_on, prox_en, wait_enable, rd_vld, led_p;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl, v;
  logic [15:0] prox_count;
  logic led_driver_output, reduced_drive_level_bit, integrating;
  logic cycle_done, prox_interrupt, out_of_range;
  logic [1:0] led_drive_strength, diode_select, analog_gain, ds;
  logic [31:0] rs = 32'h53;
  logic [15:0] rd_q[$], ev_q[$];
  int mismatches = 0, cmp_count = 0, cyc = 0, np = 0, t_prev = 0, t_last = 0;
  int p0, p1, p2, p3, p4;
  logic [7:0] thr[4];
  // Converter results and the filter outcome expected for each.
  logic [15:0] p0_tab[7] = '{16'h0050, 16'h0100, 16'h0300, 16'h0080, 16'h0200,
    16'h0201, 16'h00FF};
  logic irq_tab[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  prx_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .rd_vld(rd_vld));

  prx_meas_config #(.STEP_CYCLES(SC), .LED_HALF_CYCLES(2)) DUT (.ref_clk(ref_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_on(power_on), .proximity_enable_bit(prox_en),
    .wait_enable(wait_enable), .prox_count(prox_count),
    .led_driver_output(led_driver_output), .led_drive_strength(led_drive_strength),
    .reduced_drive_level_bit(reduced_drive_level_bit), .diode_select(diode_select),
    .analog_gain(analog_gain), .integrating(integrating), .cycle_done(cycle_done),
    .prox_interrupt(prox_interrupt), .out_of_range(out_of_range));

  // Clock of 10 ns.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Ends the run with the counts and the verdict.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Compares one result against its note.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Xorshift source of random register values.
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd

  // Notes the expected read value, then reads.
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back({8'h00, e});
    host.rd(a);
  endtask : rdc

  // Notes the expected event, then waits for the end of a cycle.
  task automatic wdone(input logic irq, input logic oor);
    int n;
    n = 0;
    ev_q.push_back({7'h00, oor, irq, 7'h03});
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (cycle_done !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      mismatches++;
      test_done();
    end
  endtask : wdone

  // Clocks between the ends of two fresh cycles.
  task automatic per(output int p);
    prox_en = 1'b1;
    repeat (2) wdone(1'b1, 1'b1);
    prox_en = 1'b0;
    // The watcher notes the end time one edge after the wait returns.
    @(posedge ref_clk);
    #1;
    p = t_last - t_prev;
  endtask : per

  // Watches outputs and takes the oldest note when a result appears.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (rd_vld === 1'b1)
      chk({8'h00, reg_rdata}, rd_q.pop_front());
    if (cycle_done === 1'b1)
    begin
      chk({7'h00, out_of_range, prox_interrupt, np[6:0]}, ev_q.pop_front());
      t_prev = t_last;
      t_last = cyc;
      np = 0;
    end
    // Pulses are counted per cycle, after the end of the previous one is checked.
    if (prox_en !== 1'b1)
      np = 0;
    else if (led_driver_output === 1'b1 && led_p !== 1'b1)
      np++;
    led_p = led_driver_output;
  end

  // Main sequence.
  initial
  begin
    reset = 1'b1;
    power_on = 1'b1;
    prox_en = 1'b0;
    wait_enable = 1'b0;
    prox_count = 16'h0000;
    repeat (20) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    for (int k = 0; k < 11; k++)
      rdc(8'(k < 2 ? 2 + k : 6 + k), k < 2 ? 8'hFF : 8'h00);
    $display("test reset values done");
    for (int a = 8; a < 12; a++)
    begin
      v = rnd();
      thr[a - 8] = v;
      host.wr(8'(a), v);
      rdc(8'(a), v);
    end
    // reserved bits are always written as zero.
    host.wr(8'h0C, 8'hF0);
    rdc(8'h0C, 8'hF0);
    host.wr(8'h0D, 8'h03);
    rdc(8'h0D, 8'h03);
    host.wr(8'h0F, 8'hEC);
    rdc(8'h0F, 8'hEC);
    host.wr(8'h11, 8'hAA);
    rdc(8'h11, 8'h00);
    $display("test register access done");
    host.wr(8'h0C, 8'h00);
    host.wr(8'h0E, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      ds = (i == 3) ? 2'd2 : 2'(i);
      ctl = {2'(i), ds, 2'(i), 2'b00};
      host.wr(8'h0D, {7'd0, 1'(i)});
      host.wr(8'h0F, ctl);
      prox_en = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      v = {integrating, led_drive_strength, diode_select, analog_gain, reduced_drive_level_bit};
      chk(16'(v), 16'({1'b1, 2'(i), ds, 2'(i), 1'(i)}));
      host.wr(8'h0F, ctl ^ 8'h0C);
      chk(16'(analog_gain), 16'(i));
      wdone(1'b1, prox_count < {thr[1], thr[0]} || prox_count > {thr[3], thr[2]});
      prox_en = 1'b0;
    end
    $display("test analog settings done");
    host.wr(8'h0D, 8'h00);
    host.wr(8'h08, 8'h00);
    host.wr(8'h09, 8'h01);
    host.wr(8'h0A, 8'h00);
    host.wr(8'h0B, 8'h02);
    host.wr(8'h0C, 8'h20);
    prox_en = 1'b1;
    foreach (p0_tab[j])
    begin
      prox_count = p0_tab[j];
      wdone(irq_tab[j], p0_tab[j] < 16'h0100 || p0_tab[j] > 16'h0200);
    end
    prox_en = 1'b0;
    $display("test persistence done");
    host.wr(8'h0C, 8'h00);
    per(p0);
    // wait time still at its reset value 0xFF before enabling.
    wait_enable = 1'b1;
    per(p1);
    host.wr(8'h03, 8'hFE);
    per(p2);
    host.wr(8'h03, 8'hFF);
    host.wr(8'h0D, 8'h02);
    per(p3);
    host.wr(8'h0D, 8'h00);
    wait_enable = 1'b0;
    host.wr(8'h02, 8'hFE);
    per(p4);
    // integration time back to a single step.
    host.wr(8'h02, 8'hFF);
    // Restarting the divider on entering the wait state costs one clock beyond its steps.
    chk(16'(p1 - p0), 16'(SC + 1));
    chk(16'(p2 - p1), 16'(SC));
    chk(16'(p3 - p1), 16'(11 * SC));
    chk(16'(p4 - p0), 16'(SC));
    $display("test timing done");
    test_done();
  end
endmodule : tb

`default_nettype wire
